// File: core/isd_flash_code.sv
// Red LED flash code generator: N pulses then a pause, or steady light
`timescale 1ns/1ps
module isd_flash_code import isd_pkg::*; #(
  parameter logic [TMR_W-1:0] PULSE_CYC = PULSE_CYC_DEF,
  parameter logic [TMR_W-1:0] GAP_CYC = GAP_CYC_DEF
) (
  input wire logic clk,
  input wire logic srst,
  isd_flash_if.gen fl
);
  isd_flash_state_t state_reg;
  logic [TMR_W-1:0] cnt_reg;
  logic [2:0] pulses_reg;
  logic led_reg;

  // Sequencer; the pulse count is compared with the current code at the end of every off phase
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= FL_IDLE;
      cnt_reg <= '0;
      pulses_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        FL_IDLE: begin
          cnt_reg <= '0;
          pulses_reg <= 3'h0;
          if (fl.code != CODE_NONE) begin
            state_reg <= FL_ON;
          end
        end
        FL_ON: begin
          if (cnt_reg >= PULSE_CYC - 1'b1) begin
            cnt_reg <= '0;
            pulses_reg <= pulses_reg + 3'h1;
            state_reg <= FL_OFF;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        FL_OFF: begin
          if (cnt_reg >= PULSE_CYC - 1'b1) begin
            cnt_reg <= '0;
            state_reg <= (pulses_reg >= fl.code) ? FL_GAP : FL_ON;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        FL_GAP: begin
          if (cnt_reg >= GAP_CYC - 1'b1) begin
            state_reg <= FL_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Steady request overrides the pulse train
  always_ff @(posedge clk) begin
    if (srst) begin
      led_reg <= 1'b0;
    end else begin
      led_reg <= fl.steady | (state_reg == FL_ON);
    end
  end

  assign fl.led = led_reg;
endmodule : isd_flash_code

// File: core/isd_flash_if.sv
// Interface between the status logic and the red flash code generator
`timescale 1ns/1ps
interface isd_flash_if;
  logic [2:0] code;
  logic steady;
  logic led;
  modport src (output code, output steady, input led);
  modport gen (input code, input steady, output led);
endinterface : isd_flash_if

// File: core/isd_interlock.sv
// Status, fault classification and serial diagnostics of a guard-locking interlock
// Notes on behaviour
// - Lock request polarity follows power-to-lock selection
// - Outputs need locked, or just closed variant
// - Diagnostic high closed-and-lockable or locked only
// - Output A fault: one pulse, 30 min
// - Output B fault: two pulses, 30 min
// - Cross short: three pulses, 30 min
// - Overtemperature: four pulses, 30 min
// - Actuator fault: five pulses, immediate off
// - Handle out of position: six pulses, off
// - Internal error: outputs off, red steady
// - Warning drops diagnostic, outputs stay on
// - Temperature warning self-clears; after 30 min shutdown
// - Serial chain replaces plain diagnostic output
// - Response byte out, request byte in
// - Lost communication holds lock and outputs
// - Error reset: bit 7 falls or open
// - Output faults held until next release
// - Request bit 0 means magnet on
// - Response bits 0, 1, 2 meanings
`timescale 1ns/1ps
module isd_interlock import isd_pkg::*; #(
  parameter logic [TMR_W-1:0] WARN_CYC = WARN_CYC_DEF,
  parameter logic [TMR_W-1:0] PULSE_CYC = PULSE_CYC_DEF,
  parameter logic [TMR_W-1:0] GAP_CYC = GAP_CYC_DEF,
  parameter logic [TMR_W-1:0] BLINK_CYC = BLINK_CYC_DEF,
  parameter logic [TMR_W-1:0] COMM_CYC = COMM_CYC_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic lock_request_in,
  input wire logic guard_closed,
  input wire logic lock_possible,
  input wire logic actuator_locked,
  input wire logic actuator_valid,
  input wire logic upstream_enable_a,
  input wire logic upstream_enable_b,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic fault_cross,
  input wire logic fault_temp,
  input wire logic fault_actuator,
  input wire logic fault_handle,
  input wire logic fault_internal,
  input wire logic sd_in,
  input wire logic sd_shift,
  input wire logic sd_latch,
  output logic sd_out,
  output logic magnet_on,
  output logic safety_output_a,
  output logic safety_output_b,
  output logic diag_out,
  output logic led_green,
  output logic led_red,
  output logic led_yellow
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic [7:0] shift_reg;
  logic [7:0] req_reg;
  logic sd_out_reg;
  logic [TMR_W-1:0] comm_cnt_reg;
  logic comm_fail_reg;
  logic bit7_fall_reg;
  logic magnet_reg;
  logic guard_d_reg;
  logic permit_d_reg;
  logic lat_a_reg;
  logic lat_b_reg;
  logic lat_cross_reg;
  logic [TMR_W-1:0] warn_cnt_reg;
  logic expired_reg;
  logic err_reg;
  logic err_int_reg;
  logic [2:0] err_code_reg;
  logic safe_reg;
  logic diag_reg;
  logic [TMR_W-1:0] blink_cnt_reg;
  logic blink_reg;
  logic green_reg;
  logic yellow_reg;
  logic [31:0] rdata_reg;
  logic [7:0] rsp_byte;
  logic ptl;
  logic open_dis;
  logic serial;
  logic lock_req;
  logic up_ok;
  logic permit;
  logic release_ev;
  logic warn_any;
  logic err_cause;
  logic err_reset_ev;
  logic [2:0] live_code;
  isd_flash_if fl ();

  assign ptl = ctrl_reg[CTRL_POWER_TO_LOCK];
  assign open_dis = ctrl_reg[CTRL_OPEN_DISABLE];
  assign serial = ctrl_reg[CTRL_SERIAL];
  assign up_ok = upstream_enable_a & upstream_enable_b;

  // Control register; variant selects are software settings
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en && addr == ADDR_CTRL) begin
      ctrl_reg <= wdata[CTRL_W-1:0];
    end
  end

  // chain shift: bits pass through to the next device
  // response loaded on latch, request captured
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_reg <= 8'h00;
      req_reg <= 8'h00;
      sd_out_reg <= 1'b0;
      bit7_fall_reg <= 1'b0;
    end else begin
      bit7_fall_reg <= 1'b0;
      if (sd_latch) begin
        req_reg <= shift_reg;
        shift_reg <= rsp_byte;
        // falling request bit 7 resets error
        bit7_fall_reg <= req_reg[REQ_ERR_RESET] & ~shift_reg[REQ_ERR_RESET];
      end else if (sd_shift) begin
        shift_reg <= {shift_reg[6:0], sd_in};
        sd_out_reg <= shift_reg[7];
      end
    end
  end

  // Watchdog on latches; the request byte is only ever replaced by a latch
  // held state on lost link
  always_ff @(posedge clk) begin
    if (srst) begin
      comm_cnt_reg <= '0;
      comm_fail_reg <= 1'b0;
    end else if (sd_latch) begin
      comm_cnt_reg <= '0;
      comm_fail_reg <= 1'b0;
    end else if (comm_cnt_reg >= COMM_CYC - 1'b1) begin
      comm_fail_reg <= serial;
    end else begin
      comm_cnt_reg <= comm_cnt_reg + 1'b1;
    end
  end

  // request bit 0 drives the magnet directly
  always_comb begin
    if (serial) begin
      lock_req = ptl ? req_reg[REQ_MAGNET] : ~req_reg[REQ_MAGNET];
    end else begin
      lock_req = ptl ? lock_request_in : ~lock_request_in;
    end
  end

  // Magnet is energised to lock or to unlock depending on the variant
  always_ff @(posedge clk) begin
    if (srst) begin
      magnet_reg <= 1'b0;
    end else begin
      magnet_reg <= ptl ? lock_req : ~lock_req;
    end
  end

  // release condition before faults are applied
  assign permit = up_ok & guard_closed & (open_dis | actuator_locked);
  assign release_ev = permit & ~permit_d_reg;

  // Edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      guard_d_reg <= 1'b0;
      permit_d_reg <= 1'b0;
    end else begin
      guard_d_reg <= guard_closed;
      permit_d_reg <= permit;
    end
  end

  // output faults held until release; a present cause wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_a_reg <= 1'b0;
      lat_b_reg <= 1'b0;
      lat_cross_reg <= 1'b0;
    end else begin
      lat_a_reg <= fault_out_a | (lat_a_reg & ~release_ev);
      lat_b_reg <= fault_out_b | (lat_b_reg & ~release_ev);
      lat_cross_reg <= fault_cross | (lat_cross_reg & ~release_ev);
    end
  end

  // temperature warning clears with its cause; output faults stay latched
  assign warn_any = lat_a_reg | lat_b_reg | lat_cross_reg | fault_temp;

  always_ff @(posedge clk) begin
    if (srst) begin
      warn_cnt_reg <= '0;
      expired_reg <= 1'b0;
    end else if (!warn_any) begin
      warn_cnt_reg <= '0;
      expired_reg <= 1'b0;
    end else if (warn_cnt_reg >= WARN_CYC - 1'b1) begin
      expired_reg <= 1'b1;
    end else begin
      warn_cnt_reg <= warn_cnt_reg + 1'b1;
    end
  end

  // immediate errors, plus an expired warning
  assign err_cause = fault_actuator | fault_handle | fault_internal | expired_reg;
  // guard opening or request bit 7 falling
  assign err_reset_ev = (guard_d_reg & ~guard_closed) | (serial & bit7_fall_reg);

  // Error latch; set wins, and reset needs the cause gone
  always_ff @(posedge clk) begin
    if (srst) begin
      err_reg <= 1'b0;
      err_int_reg <= 1'b0;
      err_code_reg <= CODE_NONE;
    end else if (err_cause) begin
      err_reg <= 1'b1;
      err_int_reg <= err_int_reg | fault_internal;
      if (live_code != CODE_NONE) begin
        err_code_reg <= live_code;
      end
    end else if (err_reset_ev) begin
      err_reg <= 1'b0;
      err_int_reg <= 1'b0;
      err_code_reg <= CODE_NONE;
    end
  end

  always_comb begin
    if (fault_handle) begin
      live_code = CODE_HANDLE;
    end else if (fault_actuator) begin
      live_code = CODE_ACTUATOR;
    end else if (lat_cross_reg | (lat_a_reg & lat_b_reg)) begin
      live_code = CODE_CROSS;
    end else if (lat_a_reg) begin
      live_code = CODE_OUT_A;
    end else if (lat_b_reg) begin
      live_code = CODE_OUT_B;
    end else if (fault_temp) begin
      live_code = CODE_TEMP;
    end else begin
      live_code = err_code_reg;
    end
  end

  // warnings keep the outputs on until expiry
  // missing upstream enable forces the outputs off
  // on lost link the frozen request keeps the state
  always_ff @(posedge clk) begin
    if (srst) begin
      safe_reg <= 1'b0;
    end else begin
      safe_reg <= permit & ~err_reg & ~err_cause;
    end
  end

  // diagnostic level, dropped on any warning or error
  // no plain diagnostic in the serial variant
  always_ff @(posedge clk) begin
    if (srst) begin
      diag_reg <= 1'b0;
    end else begin
      // Raw output faults as well, so the line drops on the edge the fault is seen
      diag_reg <= ~serial & guard_closed & (lock_possible | actuator_locked)
        & ~warn_any & ~fault_out_a & ~fault_out_b & ~fault_cross & ~err_reg & ~err_cause;
    end
  end

  // Shared 1 Hz blink for green and yellow
  always_ff @(posedge clk) begin
    if (srst) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg >= BLINK_CYC - 1'b1) begin
      blink_cnt_reg <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  // green flashes on missing upstream enable
  always_ff @(posedge clk) begin
    if (srst) begin
      green_reg <= 1'b0;
      yellow_reg <= 1'b0;
    end else begin
      green_reg <= up_ok | blink_reg;
      if (!guard_closed || err_reg) begin
        yellow_reg <= 1'b0;
      end else if (actuator_locked) begin
        yellow_reg <= 1'b1;
      end else begin
        yellow_reg <= blink_reg;
      end
    end
  end

  assign fl.steady = err_int_reg | fault_internal;
  assign fl.code = (warn_any | err_reg) ? live_code : CODE_NONE;

  isd_flash_code #(
    .PULSE_CYC(PULSE_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_flash (
    .clk(clk),
    .srst(srst),
    .fl(fl)
  );

  // response bits 0..2, then upstream, actuator, warning, error
  always_comb begin
    rsp_byte = 8'h00;
    rsp_byte[RSP_SAFE_ON] = safe_reg;
    rsp_byte[RSP_CLOSED_POSSIBLE] = guard_closed & lock_possible;
    rsp_byte[RSP_LOCKED] = actuator_locked & actuator_valid;
    rsp_byte[RSP_UPSTREAM] = up_ok;
    rsp_byte[RSP_ACT_VALID] = actuator_valid;
    rsp_byte[RSP_WARN] = warn_any;
    rsp_byte[RSP_ERROR] = err_reg;
  end

  // Read port; data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst || !rd_en) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      unique case (addr)
        ADDR_CTRL: rdata_reg <= {29'h0, ctrl_reg};
        ADDR_STATUS: rdata_reg <= {20'h0, comm_fail_reg, expired_reg, warn_any, err_reg,
          magnet_reg, safe_reg, diag_reg, yellow_reg, rsp_byte[3:0]};
        ADDR_FAULT: rdata_reg <= {23'h0, err_int_reg, fault_handle, fault_actuator,
          fault_temp, lat_cross_reg, lat_b_reg, lat_a_reg, err_code_reg[0]};
        ADDR_SERIAL: rdata_reg <= {16'h0, req_reg, rsp_byte};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign sd_out = sd_out_reg;
  assign magnet_on = magnet_reg;
  assign safety_output_a = safe_reg;
  assign safety_output_b = safe_reg;
  assign diag_out = diag_reg;
  assign led_green = green_reg;
  assign led_yellow = yellow_reg;
  assign led_red = fl.led;
endmodule : isd_interlock

// File: core/isd_pkg.sv
// Constants, field layout and timing of the interlock status block
package isd_pkg;
  // Clock and counter width
  localparam longint CLK_HZ = 10_000_000;
  localparam int TMR_W = 35;
  // Times in their own units
  localparam longint WARN_TIMEOUT_MIN = 30;
  localparam longint FLASH_PULSE_MS = 250;
  localparam longint FLASH_GAP_MS = 1000;
  localparam longint BLINK_HALF_MS = 500;
  localparam longint COMM_TIMEOUT_MS = 100;
  // Cycle counts derived from the times (all divide exactly at this clock)
  localparam logic [TMR_W-1:0] WARN_CYC_DEF = TMR_W'(WARN_TIMEOUT_MIN * 64'd60 * CLK_HZ);
  localparam logic [TMR_W-1:0] PULSE_CYC_DEF = TMR_W'(FLASH_PULSE_MS * CLK_HZ / 64'd1000);
  localparam logic [TMR_W-1:0] GAP_CYC_DEF = TMR_W'(FLASH_GAP_MS * CLK_HZ / 64'd1000);
  localparam logic [TMR_W-1:0] BLINK_CYC_DEF = TMR_W'(BLINK_HALF_MS * CLK_HZ / 64'd1000);
  localparam logic [TMR_W-1:0] COMM_CYC_DEF = TMR_W'(COMM_TIMEOUT_MS * CLK_HZ / 64'd1000);
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_SERIAL = 8'h0C;
  // Control fields
  localparam int CTRL_POWER_TO_LOCK = 0;
  localparam int CTRL_OPEN_DISABLE = 1;
  localparam int CTRL_SERIAL = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // Request byte fields
  localparam int REQ_MAGNET = 0;
  localparam int REQ_ERR_RESET = 7;
  // Response byte fields
  localparam int RSP_SAFE_ON = 0;
  localparam int RSP_CLOSED_POSSIBLE = 1;
  localparam int RSP_LOCKED = 2;
  localparam int RSP_UPSTREAM = 4;
  localparam int RSP_ACT_VALID = 5;
  localparam int RSP_WARN = 6;
  localparam int RSP_ERROR = 7;
  // Red flash codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OUT_A = 3'h1;
  localparam logic [2:0] CODE_OUT_B = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACTUATOR = 3'h5;
  localparam logic [2:0] CODE_HANDLE = 3'h6;
  // Flash generator states
  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF, FL_GAP} isd_flash_state_t;
endpackage : isd_pkg

// File: tb/isd_gateway_model.sv
// Serial diagnostic gateway model: one request byte out, one response byte in
`timescale 1ns/1ps
module isd_gateway_model (
  input wire logic clk,
  input wire logic sd_out,
  output logic sd_in,
  output logic sd_shift,
  output logic sd_latch
);
  // Line idle at time zero
  initial begin
    sd_in = 1'b0;
    sd_shift = 1'b0;
    sd_latch = 1'b0;
  end
  // single device, far below the chain limit
  // eight shifts MSB first, then latch
  task automatic frame(input logic [7:0] req, output logic [7:0] rsp);
    rsp = 8'h00;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      if (k >= 2 && k < 10) rsp = {rsp[6:0], sd_out};
      sd_shift <= (k < 8);
      sd_latch <= (k == 8);
      // Released line toggles so a stale bit is never mistaken for data
      sd_in <= (k < 8) ? req[7 - k] : ~sd_in;
    end
  endtask : frame
endmodule : isd_gateway_model

// File: tb/isd_interlock_assertions.sv
// Port-level assertions of the interlock status block
`timescale 1ns/1ps
module isd_interlock_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic guard_closed,
  input wire logic upstream_enable_a,
  input wire logic upstream_enable_b,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic fault_cross,
  input wire logic fault_temp,
  input wire logic fault_actuator,
  input wire logic fault_handle,
  input wire logic fault_internal,
  input wire logic sd_shift,
  input wire logic sd_out,
  input wire logic safety_output_a,
  input wire logic safety_output_b,
  input wire logic diag_out,
  input wire logic led_green,
  input wire logic led_red
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Grouped causes, so each property reads as one relation
  logic warn_any;
  logic err_any;
  logic up_ok;
  assign warn_any = fault_out_a | fault_out_b | fault_cross | fault_temp;
  assign err_any = fault_actuator | fault_handle | fault_internal;
  assign up_ok = upstream_enable_a & upstream_enable_b;
  // Internal error held long enough to reach the LED stage
  sequence s_internal;
    fault_internal [*4];
  endsequence
  // Warning arriving while the outputs are on
  sequence s_warn_on;
    safety_output_a && $rose(fault_temp);
  endsequence
  a_outs_equal: assert property (safety_output_a == safety_output_b)
    else $error("safety outputs differ");
  a_open_off: assert property (!guard_closed |=> !safety_output_a)
    else $error("output on with guard open");
  a_diag_open: assert property (!guard_closed |=> !diag_out)
    else $error("diagnostic high with guard open");
  a_diag_warn: assert property (warn_any |=> !diag_out)
    else $error("diagnostic high during warning");
  a_err_off: assert property (err_any |=> !safety_output_a)
    else $error("output on during error cause");
  a_red_steady: assert property (s_internal |-> led_red)
    else $error("red not lit on internal error");
  a_warn_holds: assert property (s_warn_on |=> safety_output_a [*8])
    else $error("warning dropped the outputs early");
  a_up_off: assert property (!up_ok |=> !safety_output_a)
    else $error("output on without upstream enable");
  a_green_on: assert property (up_ok [*4] |-> led_green)
    else $error("green not steady");
  a_sd_hold: assert property (!sd_shift |=> $stable(sd_out))
    else $error("serial out moved without shift");
endmodule : isd_interlock_assertions

// File: tb/isd_interlock_tb_top.sv
// Self-checking bench of the interlock status block
`timescale 1ns/1ps
module isd_interlock_tb_top import isd_pkg::*; ;
  typedef struct packed {
    logic [2:0] ctrl;
    logic [5:0] pins;
    logic [1:0] exp;
  } isd_row_t;
  logic clk;
  logic srst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic lock_request_in;
  logic [5:0] pins;
  logic [6:0] f;
  logic sd_in;
  logic sd_shift;
  logic sd_latch;
  logic sd_out;
  logic magnet_on;
  logic safety_output_a;
  logic safety_output_b;
  logic diag_out;
  logic led_green;
  logic led_red;
  logic led_yellow;
  logic [2:0] leds;
  int bad_count = 0;
  int n_compared = 0;
  // Control, pins {closed, lockable, locked, valid, up a, up b}, then {outputs, diag}
  isd_row_t rows [8] = '{'{3'h0, 6'h03, 2'h0}, '{3'h0, 6'h37, 2'h1}, '{3'h0, 6'h27, 2'h0},
    '{3'h0, 6'h3F, 2'h3}, '{3'h0, 6'h2F, 2'h3}, '{3'h2, 6'h37, 2'h3}, '{3'h2, 6'h27, 2'h2},
    '{3'h1, 6'h3F, 2'h3}};
  assign leds = {led_red, led_yellow, led_green};
  // Short timers keep the 30 minute and flash figures within a brief run
  isd_interlock #(.WARN_CYC(35'hC8), .PULSE_CYC(35'h4), .GAP_CYC(35'h8), .BLINK_CYC(35'h4),
    .COMM_CYC(35'h32)) isd_interlock_inst (
    .clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata, .lock_request_in,
    .guard_closed(pins[5]), .lock_possible(pins[4]), .actuator_locked(pins[3]),
    .actuator_valid(pins[2]), .upstream_enable_a(pins[1]), .upstream_enable_b(pins[0]),
    .fault_out_a(f[0]), .fault_out_b(f[1]), .fault_cross(f[2]), .fault_temp(f[3]),
    .fault_actuator(f[4]), .fault_handle(f[5]), .fault_internal(f[6]),
    .sd_in, .sd_shift, .sd_latch, .sd_out, .magnet_on, .safety_output_a, .safety_output_b,
    .diag_out, .led_green, .led_red, .led_yellow);
  isd_gateway_model gw (.clk, .sd_out, .sd_in, .sd_shift, .sd_latch);
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data exist only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  task automatic setp(input logic [5:0] p, input int w);
    @(posedge clk);
    pins <= p;
    repeat (w) @(posedge clk);
  endtask : setp
  // Records whether an LED was seen high and low over 20 cycles
  task automatic watch(input int w, output logic [1:0] s);
    s = 2'h0;
    repeat (20) begin
      @(posedge clk);
      s = s | {leds[w], ~leds[w]};
    end
  endtask : watch
  // Finds a pause, then counts red pulses up to the next pause
  task automatic flashes(output int n);
    int low;
    n = 0;
    low = 0;
    for (int c = 0; c < 400 && low < 6; c++) begin
      @(posedge clk);
      low = led_red ? 0 : low + 1;
    end
    low = 1;
    for (int c = 0; c < 400 && (n == 0 || low < 6); c++) begin
      @(posedge clk);
      if (led_red && low > 0) n++;
      low = led_red ? 0 : low + 1;
    end
  endtask : flashes
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [7:0] r;
    logic [1:0] s;
    int n;
    srst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    lock_request_in = 1'b0;
    pins = 6'h03;
    f = 7'h00;
    repeat (4) @(posedge clk);
    chk({safety_output_a, diag_out, leds, magnet_on}, 32'h0, "reset outputs");
    srst <= 1'b0;
    rd(ADDR_CTRL, d);
    chk(d, {29'h0, CTRL_RESET}, "ctrl reset value");
    wr(8'h10, 32'hFFFF_FFFF);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_CTRL, d);
    chk(d, 32'h0, "stray write landed");
    rd(8'h10, d);
    chk(d, 32'h0, "unmapped read");
    wr(ADDR_CTRL, 32'h7);
    rd(ADDR_CTRL, d);
    chk(d, 32'h7, "ctrl readback");
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {29'h0, rows[i].ctrl});
      setp(rows[i].pins, 4);
      chk({safety_output_a, diag_out}, rows[i].exp, "status row");
      chk(led_green, 1'b1, "green");
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, {31'h0, i[1]});
      lock_request_in <= i[0];
      repeat (3) @(posedge clk);
      chk(magnet_on, i[0], "magnet");
    end
    wr(ADDR_CTRL, 32'h0);
    setp(6'h3F, 4);
    watch(1, s);
    chk(s, 2'h2, "yellow locked");
    setp(6'h37, 4);
    watch(1, s);
    chk(s, 2'h3, "yellow unlocked");
    setp(6'h3E, 4);
    chk(safety_output_a, 1'b0, "upstream off");
    watch(0, s);
    chk(s, 2'h3, "green flash");
    setp(6'h3F, 6);
    for (int i = 1; i < 7; i++) begin
      f <= 7'h01 << (i - 1);
      repeat (3) @(posedge clk);
      chk({safety_output_a, diag_out}, {i < 5, 1'b0}, "fault outputs");
      flashes(n);
      chk(n, i, "flash count");
      f <= 7'h00;
      repeat (4) @(posedge clk);
      chk(diag_out, i == 4, "after cause");
      setp(6'h03, 4);
      setp(6'h3F, 6);
      chk({safety_output_a, diag_out}, 2'h3, "recovered");
    end
    // Both outputs faulty at once reads as a cross short
    f <= 7'h03;
    repeat (3) @(posedge clk);
    flashes(n);
    chk(n, 3, "both outputs");
    f <= 7'h00;
    setp(6'h03, 4);
    setp(6'h3F, 6);
    f <= 7'h40;
    repeat (4) @(posedge clk);
    chk(safety_output_a, 1'b0, "internal off");
    watch(2, s);
    chk(s, 2'h2, "red steady");
    f <= 7'h00;
    setp(6'h03, 4);
    setp(6'h3F, 6);
    f <= 7'h08;
    repeat (190) @(posedge clk);
    chk(safety_output_a, 1'b1, "before expiry");
    repeat (25) @(posedge clk);
    chk(safety_output_a, 1'b0, "expired");
    f <= 7'h00;
    setp(6'h03, 4);
    setp(6'h3F, 6);
    chk(safety_output_a, 1'b1, "cleared");
    wr(ADDR_CTRL, 32'h4);
    gw.frame(8'h01, r);
    chk({magnet_on, diag_out}, 2'h2, "serial magnet");
    rd(ADDR_SERIAL, d);
    chk(d[15:8], 8'h01, "request readback");
    gw.frame(8'h01, r);
    chk(r, 8'h37, "response byte");
    f <= 7'h10;
    repeat (3) @(posedge clk);
    chk(safety_output_a, 1'b0, "serial error");
    f <= 7'h00;
    gw.frame(8'h81, r);
    gw.frame(8'h01, r);
    chk(r[7], 1'b1, "error reported");
    repeat (3) @(posedge clk);
    chk(safety_output_a, 1'b1, "bit 7 reset");
    repeat (100) @(posedge clk);
    chk({magnet_on, safety_output_a}, 2'h3, "comm loss hold");
    rd(ADDR_STATUS, d);
    chk(d[11], 1'b1, "comm loss flag");
    gw.frame(8'h00, r);
    chk(magnet_on, 1'b0, "magnet off");
    // Mid-run reset must bring outputs and control back to their reset state
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({safety_output_a, diag_out, leds, magnet_on}, 32'h0, "mid-run reset");
    rd(ADDR_CTRL, d);
    chk(d, {29'h0, CTRL_RESET}, "ctrl after reset");
    print_verdict();
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : isd_interlock_tb_top
bind isd_interlock isd_interlock_assertions isd_interlock_assertions_inst (
  .clk, .srst, .guard_closed, .upstream_enable_a, .upstream_enable_b, .fault_out_a,
  .fault_out_b, .fault_cross, .fault_temp, .fault_actuator, .fault_handle, .fault_internal,
  .sd_shift, .sd_out, .safety_output_a, .safety_output_b, .diag_out, .led_green, .led_red);
